// >>> ext_bus_consts.svh
// Purpose: constants of the external bus hold and zone mode block
// Assumes: 100 MHz system clock
// Notes:   widths, reset values and timing counts
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH

// pin widths
`define EXT_ADDR_W     19
`define EXT_DATA_W     16

// clock period and fixed external access length
`define CLK_PERIOD_NS  10
`define ACCESS_NS      40
`define ACCESS_CYC     ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CNT_W      4

// boot mode capture: edges after reset release up to the one that latches
// the pin; the synchroniser sits in reset too, so two edges must refill it
`define MODE_SETTLE    2'h3
`define MODE_RST       1'b0

// idle levels of active-low pins
`define STROBE_IDLE    1'b1
`define GRANT_IDLE     1'b1

`endif

// >>> ext_bus_pkg.sv
// Purpose: types of the external bus hold and zone mode block
// Assumes: nothing beyond the constants header
// Notes:   state encoding is left to the tool
package ext_bus_pkg;

  // bus owner state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_HOLD
  } state_t;

endpackage

// >>> ext_bus_hold.sv
// Purpose: external parallel interface pins, hold arbitration, zone 7 map
// Assumes: cpu side on sys_clk; hold request and pins are asynchronous
// Notes:   the pin pullups live in the pad ring, not in this logic
`timescale 1ns/100ps
`include "ext_bus_consts.svh"

module ext_bus_hold (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // cpu access path
  input  wire logic                    cpu_req,
  input  wire logic                    cpu_wr,
  input  wire logic                    cpu_zone7,
  input  wire logic [`EXT_ADDR_W-1:0]  cpu_addr,
  input  wire logic [`EXT_DATA_W-1:0]  cpu_wdata,
  output logic                         cpu_ready,
  output logic                         cpu_done,
  output logic [`EXT_DATA_W-1:0]       cpu_rdata,
  // boot rom redirect
  output logic                         rom_req,
  output logic [`EXT_ADDR_W-1:0]       rom_addr,
  // mode bit of the second interface configuration register
  input  wire logic                    mode_wr_en,
  input  wire logic                    mode_wr_data,
  output logic                         mode_bit,
  // mode select pin
  input  wire logic                    boot_mode_select,
  // address pins
  output logic [`EXT_ADDR_W-1:0]       ext_addr_bus,
  output logic                         ext_addr_oe,
  // data pins
  input  wire logic [`EXT_DATA_W-1:0]  ext_data_in,
  output logic [`EXT_DATA_W-1:0]       ext_data_out,
  output logic                         ext_data_oe,
  // strobes active low, their output enable active high
  output logic                         ext_rd_n,
  output logic                         ext_wr_n,
  output logic                         ext_strobe_oe,
  // hold handshake, active low
  input  wire logic                    bus_hold_request_n,
  output logic                         bus_hold_grant_n
);
  import ext_bus_pkg::*;

  // synchronisers for asynchronous pins
  logic [1:0]              hold_sync_r;
  logic [1:0]              mode_sync_r;
  logic [`EXT_DATA_W-1:0]  din_meta_r;
  logic [`EXT_DATA_W-1:0]  din_sync_r;

  // state and next values
  state_t                  state_r, state_nxt;
  logic [`ACC_CNT_W-1:0]   cnt_r, cnt_nxt;
  logic                    pend_r, pend_nxt;
  logic                    p_wr_r, p_wr_nxt;
  logic                    p_z7_r, p_z7_nxt;
  logic [`EXT_ADDR_W-1:0]  p_addr_r, p_addr_nxt;
  logic [`EXT_DATA_W-1:0]  p_data_r, p_data_nxt;
  logic [1:0]              settle_r, settle_nxt;
  logic                    mode_r, mode_nxt;
  logic                    ready_r, ready_nxt;
  logic                    done_r, done_nxt;
  logic [`EXT_DATA_W-1:0]  rdata_r, rdata_nxt;
  logic                    rom_req_r, rom_req_nxt;
  logic [`EXT_ADDR_W-1:0]  rom_addr_r, rom_addr_nxt;
  logic [`EXT_ADDR_W-1:0]  addr_r, addr_nxt;
  logic                    addr_oe_r, addr_oe_nxt;
  logic [`EXT_DATA_W-1:0]  dout_r, dout_nxt;
  logic                    dout_oe_r, dout_oe_nxt;
  logic                    rd_n_r, rd_n_nxt;
  logic                    wr_n_r, wr_n_nxt;
  logic                    strb_oe_r, strb_oe_nxt;
  logic                    grant_n_r, grant_n_nxt;

  logic                    hold_req;
  logic                    last_cyc;

  // hold request is active high once inverted after both flip-flops
  assign hold_req = ~hold_sync_r[1];
  assign last_cyc = (cnt_r == `ACC_CNT_W'(`ACCESS_CYC - 1));

  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_sync_r <= 2'h3;
      mode_sync_r <= 2'h0;
      din_meta_r  <= `EXT_DATA_W'h0;
      din_sync_r  <= `EXT_DATA_W'h0;
    end
    else
    begin
      hold_sync_r <= {hold_sync_r[0], bus_hold_request_n};
      mode_sync_r <= {mode_sync_r[0], boot_mode_select};
      din_meta_r  <= ext_data_in;
      din_sync_r  <= din_meta_r;
    end
  end

  // next values of mode bit, request latch and bus state
  always_comb
  begin
    settle_nxt   = settle_r;
    mode_nxt     = mode_r;
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    pend_nxt     = pend_r;
    p_wr_nxt     = p_wr_r;
    p_z7_nxt     = p_z7_r;
    p_addr_nxt   = p_addr_r;
    p_data_nxt   = p_data_r;
    done_nxt     = 1'b0;
    rdata_nxt    = rdata_r;
    rom_req_nxt  = 1'b0;
    rom_addr_nxt = rom_addr_r;
    addr_nxt     = addr_r;
    addr_oe_nxt  = addr_oe_r;
    dout_nxt     = dout_r;
    dout_oe_nxt  = 1'b0;
    rd_n_nxt     = `STROBE_IDLE;
    wr_n_nxt     = `STROBE_IDLE;
    strb_oe_nxt  = strb_oe_r;
    grant_n_nxt  = grant_n_r;

    // pin caught once after release, then only software changes it
    if (settle_r != `MODE_SETTLE)
    begin
      settle_nxt = settle_r + 2'h1;
      if (settle_r + 2'h1 == `MODE_SETTLE)
        mode_nxt = mode_sync_r[1];
    end
    else if (mode_wr_en)
      mode_nxt = mode_wr_data;

    // latch a new cpu request
    if (cpu_req && ready_r)
    begin
      pend_nxt   = 1'b1;
      p_wr_nxt   = cpu_wr;
      p_z7_nxt   = cpu_zone7;
      p_addr_nxt = cpu_addr;
      p_data_nxt = cpu_wdata;
    end

    case (state_r)
      ST_IDLE:
      begin
        if (pend_r && p_z7_r && !mode_r)
        begin
          pend_nxt     = 1'b0;
          rom_req_nxt  = 1'b1;
          rom_addr_nxt = p_addr_r;
          done_nxt     = 1'b1;
        end
        else if (pend_r)
        begin
          pend_nxt    = 1'b0;
          state_nxt   = ST_ACCESS;
          cnt_nxt     = `ACC_CNT_W'h0;
          addr_nxt    = p_addr_r;
          addr_oe_nxt = 1'b1;
          strb_oe_nxt = 1'b1;
          dout_nxt    = p_data_r;
          dout_oe_nxt = p_wr_r;
          rd_n_nxt    = p_wr_r;
          wr_n_nxt    = ~p_wr_r;
        end
        else if (hold_req && !(cpu_req && ready_r))
        begin
          state_nxt   = ST_HOLD;
          addr_oe_nxt = 1'b0;
          strb_oe_nxt = 1'b0;
          grant_n_nxt = 1'b0;
        end
      end
      ST_ACCESS:
      begin
        cnt_nxt     = cnt_r + `ACC_CNT_W'h1;
        dout_oe_nxt = p_wr_r & ~last_cyc;
        rd_n_nxt    = p_wr_r | last_cyc;
        wr_n_nxt    = ~p_wr_r | last_cyc;
        if (last_cyc)
        begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
          if (!p_wr_r)
            rdata_nxt = din_sync_r;
        end
      end
      ST_HOLD:
      begin
        // outside master owns the pins until it withdraws
        addr_oe_nxt = 1'b0;
        strb_oe_nxt = 1'b0;
        if (!hold_req)
        begin
          state_nxt   = ST_IDLE;
          grant_n_nxt = `GRANT_IDLE;
          addr_oe_nxt = 1'b1;
          strb_oe_nxt = 1'b1;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase

    ready_nxt = (state_nxt == ST_IDLE) && !pend_nxt && !done_nxt;
  end

  // register all state and pin drivers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      settle_r   <= 2'h0;
      mode_r     <= `MODE_RST;
      state_r    <= ST_IDLE;
      cnt_r      <= `ACC_CNT_W'h0;
      pend_r     <= 1'b0;
      p_wr_r     <= 1'b0;
      p_z7_r     <= 1'b0;
      p_addr_r   <= `EXT_ADDR_W'h0;
      p_data_r   <= `EXT_DATA_W'h0;
      ready_r    <= 1'b0;
      done_r     <= 1'b0;
      rdata_r    <= `EXT_DATA_W'h0;
      rom_req_r  <= 1'b0;
      rom_addr_r <= `EXT_ADDR_W'h0;
      addr_r     <= `EXT_ADDR_W'h0;
      addr_oe_r  <= 1'b1;
      dout_r     <= `EXT_DATA_W'h0;
      dout_oe_r  <= 1'b0;
      rd_n_r     <= `STROBE_IDLE;
      wr_n_r     <= `STROBE_IDLE;
      strb_oe_r  <= 1'b1;
      grant_n_r  <= `GRANT_IDLE;
    end
    else
    begin
      settle_r   <= settle_nxt;
      mode_r     <= mode_nxt;
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      pend_r     <= pend_nxt;
      p_wr_r     <= p_wr_nxt;
      p_z7_r     <= p_z7_nxt;
      p_addr_r   <= p_addr_nxt;
      p_data_r   <= p_data_nxt;
      ready_r    <= ready_nxt;
      done_r     <= done_nxt;
      rdata_r    <= rdata_nxt;
      rom_req_r  <= rom_req_nxt;
      rom_addr_r <= rom_addr_nxt;
      addr_r     <= addr_nxt;
      addr_oe_r  <= addr_oe_nxt;
      dout_r     <= dout_nxt;
      dout_oe_r  <= dout_oe_nxt;
      rd_n_r     <= rd_n_nxt;
      wr_n_r     <= wr_n_nxt;
      strb_oe_r  <= strb_oe_nxt;
      grant_n_r  <= grant_n_nxt;
    end
  end

  // outputs straight from flip-flops
  assign cpu_ready     = ready_r;
  assign cpu_done      = done_r;
  assign cpu_rdata     = rdata_r;
  assign rom_req       = rom_req_r;
  assign rom_addr      = rom_addr_r;
  assign mode_bit      = mode_r;
  assign ext_addr_bus  = addr_r;
  assign ext_addr_oe   = addr_oe_r;
  assign ext_data_out  = dout_r;
  assign ext_data_oe   = dout_oe_r;
  assign ext_rd_n      = rd_n_r;
  assign ext_wr_n      = wr_n_r;
  assign ext_strobe_oe = strb_oe_r;
  assign bus_hold_grant_n = grant_n_r;

endmodule

// >>> ext_bus_hold_props.sv
// Purpose: port checks of the hold and zone block
// Assumes: one clock, reset active high
// Notes:   bound into every instance of the block
`timescale 1ns/100ps
module ext_bus_hold_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // cpu side
  input wire logic        cpu_req,
  input wire logic        cpu_ready,
  input wire logic        cpu_wr,
  input wire logic        cpu_zone7,
  input wire logic [18:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic        cpu_done,
  input wire logic        rom_req,
  input wire logic [18:0] rom_addr,
  input wire logic        mode_bit,
  // pins
  input wire logic [18:0] ext_addr_bus,
  input wire logic        ext_addr_oe,
  input wire logic [15:0] ext_data_out,
  input wire logic        ext_data_oe,
  input wire logic        ext_rd_n,
  input wire logic        ext_wr_n,
  input wire logic        ext_strobe_oe,
  input wire logic        bus_hold_request_n,
  input wire logic        bus_hold_grant_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // pins float while the grant is out
  a_hold_float: assert property (
    !bus_hold_grant_n |-> !ext_addr_oe && !ext_strobe_oe && !ext_data_oe)
    else $error("bus driven in hold");
  // grant returns soon after the request is withdrawn
  a_grant_back: assert property (
    $rose(bus_hold_request_n) && !bus_hold_grant_n
    |-> ##[1:4] bus_hold_grant_n) else $error("grant kept");
  // the request passes two flip-flops first, so the grant waits three edges
  a_sync_delay: assert property (
    $fell(bus_hold_request_n) && bus_hold_grant_n
    |-> bus_hold_grant_n[*3]) else $error("grant too early");
  // no grant while a strobe was active
  a_grant_idle: assert property (
    $fell(bus_hold_grant_n) |-> $past(ext_rd_n) && $past(ext_wr_n))
    else $error("grant in access");
  // zone 7 goes to the rom when the mode bit is low
  a_rom_route: assert property (
    cpu_req && cpu_ready && cpu_zone7 && !mode_bit && bus_hold_grant_n
    |-> ##2 rom_req && cpu_done && rom_addr == $past(cpu_addr, 2))
    else $error("rom redirect wrong");
  // zone 7 goes out when the mode bit is high
  a_zone7_ext: assert property (
    cpu_req && cpu_ready && cpu_zone7 && mode_bit && bus_hold_grant_n
    |-> ##6 cpu_done && !rom_req) else $error("zone 7 not out");
  // read drives the address pins
  a_read_addr: assert property (
    cpu_req && cpu_ready && !cpu_wr && !cpu_zone7 && bus_hold_grant_n
    |-> ##2 !ext_rd_n && ext_addr_oe && ext_addr_bus == $past(cpu_addr, 2))
    else $error("read address wrong");
  // write drives the data pins
  a_write_data: assert property (
    cpu_req && cpu_ready && cpu_wr && !cpu_zone7 && bus_hold_grant_n
    |-> ##2 !ext_wr_n && ext_data_oe && ext_data_out == $past(cpu_wdata, 2))
    else $error("write data wrong");
endmodule
bind ext_bus_hold ext_bus_hold_chk u_chk (.sys_clk, .rst, .cpu_req,
  .cpu_ready, .cpu_wr, .cpu_zone7, .cpu_addr, .cpu_wdata, .cpu_done,
  .rom_req, .rom_addr, .mode_bit, .ext_addr_bus, .ext_addr_oe,
  .ext_data_out, .ext_data_oe, .ext_rd_n, .ext_wr_n, .ext_strobe_oe,
  .bus_hold_request_n, .bus_hold_grant_n);

// >>> ext_mem_model.sv
// Purpose: memory and outside master on the pin side
// Assumes: sixteen words indexed by the low address bits
// Notes:   resolves the data lines, pullup when nobody drives
`timescale 1ns/100ps
module ext_mem_model (
  // clock
  input  wire logic        sys_clk,
  // device pins
  input  wire logic [18:0] ext_addr_bus,
  input  wire logic [15:0] ext_data_out,
  input  wire logic        ext_data_oe,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  input  wire logic        ext_strobe_oe,
  input  wire logic        bus_hold_grant_n,
  // outside master command
  input  wire logic        master_en,
  // resolved data lines
  output logic      [15:0] ext_data_in
);
  logic [15:0] mem [16];
  // wire level: device, memory, granted master, else pullup
  always_comb
  begin
    if (ext_data_oe)
      ext_data_in = ext_data_out;
    else if (ext_strobe_oe && !ext_rd_n)
      ext_data_in = mem[ext_addr_bus[3:0]];
    else if (master_en && !bus_hold_grant_n)
      ext_data_in = 16'h3C3C;
    else
      ext_data_in = 16'hFFFF;
  end
  // store while the write strobe is low
  always @(posedge sys_clk)
    if (ext_strobe_oe && !ext_wr_n && ext_data_oe)
      mem[ext_addr_bus[3:0]] <= ext_data_out;
endmodule

// >>> tb_ext_bus_hold.sv
// Purpose: self-checking bench of the hold and zone block
// Assumes: inputs change on the falling edge
// Notes:   boot pin high at reset, so zone 7 starts external
`timescale 1ns/100ps
module tb_ext_bus_hold;
  logic sys_clk, rst, cpu_req, cpu_wr, cpu_zone7, cpu_ready, cpu_done;
  logic rom_req, mode_wr_en, mode_wr_data, mode_bit, boot_mode_select;
  logic ext_addr_oe, ext_data_oe, ext_rd_n, ext_wr_n, ext_strobe_oe;
  logic bus_hold_request_n, bus_hold_grant_n, master_en;
  logic [18:0] cpu_addr, rom_addr, ext_addr_bus;
  logic [15:0] cpu_wdata, cpu_rdata, ext_data_in, ext_data_out;
  int          mismatches, checks_done;
  ext_bus_hold u_dut (.sys_clk, .rst, .cpu_req, .cpu_wr, .cpu_zone7,
    .cpu_addr, .cpu_wdata, .cpu_ready, .cpu_done, .cpu_rdata, .rom_req,
    .rom_addr, .mode_wr_en, .mode_wr_data, .mode_bit, .boot_mode_select,
    .ext_addr_bus, .ext_addr_oe, .ext_data_in, .ext_data_out,
    .ext_data_oe, .ext_rd_n, .ext_wr_n, .ext_strobe_oe,
    .bus_hold_request_n, .bus_hold_grant_n);
  ext_mem_model u_mem (.sys_clk, .ext_addr_bus, .ext_data_out,
    .ext_data_oe, .ext_rd_n, .ext_wr_n, .ext_strobe_oe,
    .bus_hold_grant_n, .master_en, .ext_data_in);
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic chk(input logic [18:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // bounded wait for a level
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v)
    begin
      @(negedge sys_clk);
      n++;
      if (n > 40)
      begin
        mismatches++;
        give_verdict();
      end
    end
  endtask
  // one access request
  task automatic issue(input logic w, z, input logic [18:0] a,
                       input logic [15:0] d);
    wait_lvl(cpu_ready, 1'b1);
    {cpu_wr, cpu_zone7, cpu_addr, cpu_wdata} = {w, z, a, d};
    cpu_req = 1'b1;
    @(negedge sys_clk);
    cpu_req = 1'b0;
  endtask
  task automatic acc(input logic w, z, input logic [18:0] a,
                     input logic [15:0] d);
    issue(w, z, a, d);
    wait_lvl(cpu_done, 1'b1);
  endtask
  // latched pin, later pin changes ignored
  task automatic t_mode();
    repeat (4) @(negedge sys_clk);
    chk(mode_bit, 1'b1);
    boot_mode_select = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(mode_bit, 1'b1);
  endtask
  // external write and read back, zone 7 outside
  task automatic t_ext();
    acc(1'b1, 1'b0, 19'h00005, 16'hA5C3);
    acc(1'b1, 1'b1, 19'h7FFFF, 16'h5A3C);
    acc(1'b0, 1'b0, 19'h00005, 16'h0000);
    chk(cpu_rdata, 16'hA5C3);
    acc(1'b0, 1'b1, 19'h7FFFF, 16'h0000);
    chk(rom_req, 1'b0);
    chk(cpu_rdata, 16'h5A3C);
    chk(ext_data_in, 16'hFFFF);
  endtask
  // mode cleared by software sends zone 7 to rom
  task automatic t_rom();
    {mode_wr_en, mode_wr_data} = 2'h2;
    @(negedge sys_clk);
    mode_wr_en = 1'b0;
    @(negedge sys_clk);
    chk(mode_bit, 1'b0);
    acc(1'b0, 1'b1, 19'h00123, 16'h0000);
    chk(rom_req, 1'b1);
    chk(rom_addr, 19'h00123);
  endtask
  // hold raised during a read, grant, master, withdraw
  task automatic t_hold();
    issue(1'b0, 1'b0, 19'h00005, 16'h0000);
    bus_hold_request_n = 1'b0;
    wait_lvl(cpu_done, 1'b1);
    chk(bus_hold_grant_n, 1'b1);
    chk(cpu_rdata, 16'hA5C3);
    wait_lvl(bus_hold_grant_n, 1'b0);
    chk({ext_addr_oe, ext_strobe_oe, ext_data_oe}, 3'h0);
    master_en = 1'b1;
    @(negedge sys_clk);
    chk(ext_data_in, 16'h3C3C);
    {master_en, bus_hold_request_n} = 2'h1;
    wait_lvl(bus_hold_grant_n, 1'b1);
    chk(ext_addr_oe, 1'b1);
  endtask
  // reset and sequence
  initial
  begin
    {mismatches, checks_done} = '0;
    {cpu_req, cpu_wr, cpu_zone7, cpu_addr, cpu_wdata} = '0;
    {mode_wr_en, mode_wr_data, master_en} = '0;
    {rst, boot_mode_select, bus_hold_request_n} = 3'h7;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    t_mode();
    t_ext();
    t_rom();
    t_hold();
    give_verdict();
  end
endmodule
